/* File: hdl/uda_pkg.sv */
package uda_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] UDA_FUNCTION_ADDRESS_OFS = 4'h0;
    localparam logic [3:0] UDA_POWER_CTRL_OFS = 4'h4;
    localparam logic [3:0] UDA_IRQ_FLAGS_OFS = 4'h8;
    localparam logic [3:0] UDA_IRQ_ENABLE_OFS = 4'hc;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int UDA_ADDR_PENDING_BIT = 7;
    localparam int UDA_SUSPEND_DETECT_BIT = 0;
    localparam int UDA_SUSPENDED_BIT = 1;
    localparam int UDA_RESUME_BIT = 2;
    localparam int UDA_BUS_RESET_BIT = 3;
    localparam int UDA_INHIBIT_BIT = 4;
    localparam int UDA_ISO_SYNC_BIT = 7;
    localparam int UDA_IRQ_RESET_BIT = 0;
    localparam int UDA_IRQ_SUSPEND_BIT = 1;
    localparam int UDA_IRQ_RESUME_BIT = 2;
    // ----------------------------------------
    // Reset values, endpoint and stage counts
    // ----------------------------------------
    localparam logic [7:0] UDA_FUNCTION_ADDRESS_RST = 8'h00;
    localparam logic [7:0] UDA_POWER_CTRL_RST = 8'h10;
    localparam logic [2:0] UDA_IRQ_ENABLE_RST = 3'h5;
    localparam logic [2:0] UDA_IRQ_ENABLE_BUS_RESET = 3'h5;
    localparam logic [7:0] UDA_CSR_CLEAR = 8'h00;
    localparam int UDA_ISO_EP_COUNT = 3;
    localparam int UDA_SYNC_STAGES = 2;
endpackage

/* File: hdl/uda_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for one pin level
module uda_sync
    import uda_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    logic stage1;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            level <= stage1;
        end
    end
endmodule // uda_sync

/* File: hdl/uda_iso_gate.sv */
`timescale 1ns/1ps
// One isochronous IN endpoint: hold a new packet until SOF when framing on
module uda_iso_gate
    import uda_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic frame_sync,
    input wire logic packet_loaded,
    input wire logic sof_seen,
    input wire logic in_token,
    output logic packet_release,
    output logic send_zero_length
);
    logic held;
    wire logic next_held = (packet_loaded & frame_sync) | (held & ~sof_seen);

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            held <= 1'b0;
            packet_release <= 1'b0;
            send_zero_length <= 1'b0;
        end
        else
        begin
            held <= next_held & frame_sync;
            packet_release <= held & sof_seen;
            send_zero_length <= in_token & frame_sync & (held | packet_loaded);
        end
    end

    iso_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        packet_loaded && frame_sync && !sof_seen |=> held)
        else $error("iso packet not held");
    iso_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
        in_token && frame_sync && held |=> send_zero_length)
        else $error("no zero length answer");
endmodule // uda_iso_gate

/* File: hdl/uda_ctrl.sv */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module uda_ctrl
    import uda_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Bus line events from the transceiver side (asynchronous levels)
    input wire logic bus_reset_pin,
    input wire logic bus_suspend_pin,
    input wire logic bus_resume_pin,
    // Packet engine events, same clock
    input wire logic transfer_done,
    input wire logic sof_seen,
    input wire logic [2:0] iso_packet_loaded,
    input wire logic [2:0] iso_in_token,
    // Outputs
    output logic [6:0] match_address,
    output logic port_enabled,
    output logic suspended,
    output logic drive_resume,
    output logic fifo_flush,
    output logic csr_clear,
    output logic [2:0] iso_release,
    output logic [2:0] iso_zero_length,
    output logic irq
);
    // ----------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------
    logic rst_lvl;
    logic sus_lvl;
    logic res_lvl;
    logic rst_d;
    logic sus_d;
    logic res_d;

    uda_sync u_sync_rst (.ref_clk(ref_clk), .reset(reset), .pin(bus_reset_pin), .level(rst_lvl));
    uda_sync u_sync_sus (.ref_clk(ref_clk), .reset(reset), .pin(bus_suspend_pin), .level(sus_lvl));
    uda_sync u_sync_res (.ref_clk(ref_clk), .reset(reset), .pin(bus_resume_pin), .level(res_lvl));

    // ----------------------------------------
    // Software USB reset (async) request
    // ----------------------------------------
    logic soft_reset_req;
    logic usb_reset;
    wire logic addr_sel = (avs_address == UDA_FUNCTION_ADDRESS_OFS);
    wire logic pwr_sel = (avs_address == UDA_POWER_CTRL_OFS);
    wire logic flg_sel = (avs_address == UDA_IRQ_FLAGS_OFS);
    wire logic ena_sel = (avs_address == UDA_IRQ_ENABLE_OFS);
    wire logic wr_pwr = avs_write & pwr_sel;
    wire logic soft_reset_write = wr_pwr & avs_writedata[UDA_BUS_RESET_BIT];

    // Pulse registered on the system reset only, so it can self-clear
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            soft_reset_req <= 1'b0;
        else
            soft_reset_req <= soft_reset_write;
    end

    assign usb_reset = reset | soft_reset_req;

    // ----------------------------------------
    // Bus side
    // ----------------------------------------
    // One wait state on reads so read data stand when waitrequest drops
    logic read_done;
    assign avs_waitrequest = avs_read & ~read_done;

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            rst_d <= 1'b0;
            sus_d <= 1'b0;
            res_d <= 1'b0;
        end
        else
        begin
            rst_d <= rst_lvl;
            sus_d <= sus_lvl;
            res_d <= res_lvl;
        end
    end

    wire logic bus_reset_evt = rst_lvl & ~rst_d;
    wire logic suspend_evt = sus_lvl & ~sus_d;
    wire logic resume_evt = res_lvl & ~res_d;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [6:0] addr_written;
    logic addr_pending;
    logic suspend_detect_enable;
    logic remote_wakeup;
    logic port_inhibit;
    logic iso_frame_sync;
    logic bus_reset_flag;
    logic [2:0] irq_flags;
    logic [2:0] irq_enable;

    wire logic wr_addr = avs_write & addr_sel;
    wire logic wr_flg = avs_write & flg_sel;
    wire logic wr_ena = avs_write & ena_sel;
    wire logic enter_suspend = suspend_detect_enable & suspend_evt & ~port_inhibit;
    wire logic leave_suspend = resume_evt | remote_wakeup | bus_reset_evt;
    wire logic [2:0] set_flags = {resume_evt & ~port_inhibit, enter_suspend, bus_reset_evt};
    // W1C with set winning
    wire logic [2:0] next_irq_flags = (irq_flags & ~(wr_flg ? avs_writedata[2:0] : 3'h0)) | set_flags;

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            addr_written <= UDA_FUNCTION_ADDRESS_RST[6:0];
            addr_pending <= 1'b0;
            match_address <= UDA_FUNCTION_ADDRESS_RST[6:0];
        end
        else if (bus_reset_evt)
        begin
            addr_written <= UDA_FUNCTION_ADDRESS_RST[6:0];
            addr_pending <= 1'b0;
            match_address <= UDA_FUNCTION_ADDRESS_RST[6:0];
        end
        else if (wr_addr)
        begin
            addr_written <= avs_writedata[6:0];
            addr_pending <= 1'b1;
        end
        else if (addr_pending & transfer_done)
        begin
            match_address <= addr_written;
            addr_pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            suspend_detect_enable <= UDA_POWER_CTRL_RST[UDA_SUSPEND_DETECT_BIT];
            remote_wakeup <= UDA_POWER_CTRL_RST[UDA_RESUME_BIT];
            port_inhibit <= UDA_POWER_CTRL_RST[UDA_INHIBIT_BIT];
            iso_frame_sync <= UDA_POWER_CTRL_RST[UDA_ISO_SYNC_BIT];
        end
        else if (wr_pwr)
        begin
            suspend_detect_enable <= avs_writedata[UDA_SUSPEND_DETECT_BIT];
            remote_wakeup <= avs_writedata[UDA_RESUME_BIT];
            port_inhibit <= port_inhibit & avs_writedata[UDA_INHIBIT_BIT];
            iso_frame_sync <= avs_writedata[UDA_ISO_SYNC_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            bus_reset_flag <= 1'b0;
            suspended <= 1'b0;
        end
        else
        begin
            bus_reset_flag <= rst_lvl;
            if (leave_suspend)
                suspended <= 1'b0;
            else if (enter_suspend)
                suspended <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            irq_flags <= 3'h0;
            irq_enable <= UDA_IRQ_ENABLE_RST;
        end
        else if (bus_reset_evt)
        begin
            irq_flags <= 3'h1;
            irq_enable <= UDA_IRQ_ENABLE_BUS_RESET;
        end
        else
        begin
            irq_flags <= next_irq_flags;
            if (wr_ena)
                irq_enable <= avs_writedata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge usb_reset)
    begin
        if (usb_reset)
        begin
            fifo_flush <= 1'b0;
            csr_clear <= 1'b0;
        end
        else
        begin
            fifo_flush <= bus_reset_evt;
            csr_clear <= bus_reset_evt;
        end
    end

    assign irq = |(irq_flags & irq_enable);
    assign port_enabled = ~port_inhibit;
    assign drive_resume = remote_wakeup;

    // ----------------------------------------
    // Isochronous IN framing
    // ----------------------------------------
    genvar ep;
    generate
        for (ep = 0; ep < UDA_ISO_EP_COUNT; ep++)
        begin : g_iso
            uda_iso_gate u_gate (
                .ref_clk(ref_clk),
                .reset(usb_reset),
                .frame_sync(iso_frame_sync),
                .packet_loaded(iso_packet_loaded[ep]),
                .sof_seen(sof_seen),
                .in_token(iso_in_token[ep]),
                .packet_release(iso_release[ep]),
                .send_zero_length(iso_zero_length[ep])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire logic [7:0] addr_view = {addr_pending, addr_written};
    wire logic [7:0] pwr_view = {iso_frame_sync, 2'b00, port_inhibit, bus_reset_flag, remote_wakeup,
                                 suspended, suspend_detect_enable};
    wire logic [7:0] rd_mux = addr_sel ? addr_view :
                              pwr_sel ? pwr_view :
                              flg_sel ? {5'h00, irq_flags} :
                              ena_sel ? {5'h00, irq_enable} : 8'h00;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            avs_readdata <= 32'h0000_0000;
            read_done <= 1'b0;
        end
        else
        begin
            read_done <= avs_waitrequest;
            if (avs_waitrequest)
                avs_readdata <= {24'h000000, rd_mux};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    addr_hold_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        addr_pending && !transfer_done && !bus_reset_evt |=> $stable(match_address))
        else $error("address changed before transfer end");
    pend_set_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        wr_addr && !bus_reset_evt |=> addr_pending)
        else $error("pending flag not set");
    pend_clear_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        addr_pending && transfer_done && !wr_addr && !bus_reset_evt
        |=> !addr_pending && match_address == $past(addr_written))
        else $error("pending cleared wrongly");
    rst_status_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        rst_lvl |=> bus_reset_flag)
        else $error("bus reset status not set");
    rst_clear_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        bus_reset_evt |=> match_address == 7'h00 && fifo_flush && csr_clear)
        else $error("bus reset did not clear");
    rst_irq_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        bus_reset_evt |=> irq_flags == 3'h1 && irq_enable == UDA_IRQ_ENABLE_BUS_RESET ##0 irq)
        else $error("reset interrupt missing");
    sus_enter_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        enter_suspend && !leave_suspend |=> suspended && irq_flags[UDA_IRQ_SUSPEND_BIT])
        else $error("suspend not entered");
    sus_leave_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        leave_suspend |=> !suspended)
        else $error("suspend not left");
    inhibit_hold_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        !port_inhibit |=> !port_inhibit)
        else $error("inhibit set by software");
    res_irq_a: assert property (@(posedge ref_clk) disable iff (usb_reset)
        resume_evt && !port_inhibit && !bus_reset_evt |=> irq_flags[UDA_IRQ_RESUME_BIT])
        else $error("resume flag not set");
    avalon_ready_a: assert property (@(posedge ref_clk) disable iff (reset)
        avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    read_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
        avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read wait too long");
endmodule // uda_ctrl

/* File: tb/uda_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host side: bus signaling and packet engine events
// ----------------------------------------
module uda_host_model
(
    input wire logic ref_clk,
    output logic bus_reset_pin,
    output logic bus_suspend_pin,
    output logic bus_resume_pin,
    output logic transfer_done,
    output logic sof_seen,
    output logic [2:0] iso_packet_loaded,
    output logic [2:0] iso_in_token
);
    logic [2:0] line = 3'h0;
    logic [7:0] ev = 8'h00;
    assign bus_reset_pin = line[0];
    assign bus_suspend_pin = line[1];
    assign bus_resume_pin = line[2];
    assign transfer_done = ev[0];
    assign sof_seen = ev[1];
    assign iso_packet_loaded = ev[4:2];
    assign iso_in_token = ev[7:5];
    // Lines idle low between signaling periods
    task automatic signal_line(input int which, input int cycles);
        @(posedge ref_clk);
        line[which] <= 1'b1;
        repeat (cycles) @(posedge ref_clk);
        line[which] <= 1'b0;
    endtask
    // One-cycle event pulses
    task automatic pulse(input logic [7:0] mask);
        @(posedge ref_clk);
        ev <= mask;
        @(posedge ref_clk);
        ev <= 8'h00;
    endtask
endmodule // uda_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import uda_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, bus_reset_pin, bus_suspend_pin, bus_resume_pin, transfer_done, sof_seen;
    logic [2:0] iso_packet_loaded, iso_in_token, iso_release, iso_zero_length;
    logic [6:0] match_address;
    logic port_enabled, suspended, drive_resume, fifo_flush, csr_clear, irq;
    logic [7:0] seen = 8'h00;
    logic seen_clear = 1'b0;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    uda_ctrl uda_ctrl_i (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_reset_pin(bus_reset_pin), .bus_suspend_pin(bus_suspend_pin),
        .bus_resume_pin(bus_resume_pin), .transfer_done(transfer_done), .sof_seen(sof_seen),
        .iso_packet_loaded(iso_packet_loaded), .iso_in_token(iso_in_token), .match_address(match_address),
        .port_enabled(port_enabled), .suspended(suspended), .drive_resume(drive_resume),
        .fifo_flush(fifo_flush), .csr_clear(csr_clear), .iso_release(iso_release),
        .iso_zero_length(iso_zero_length), .irq(irq));
    uda_host_model uda_host_model_i (.ref_clk(ref_clk), .bus_reset_pin(bus_reset_pin),
        .bus_suspend_pin(bus_suspend_pin), .bus_resume_pin(bus_resume_pin), .transfer_done(transfer_done),
        .sof_seen(sof_seen), .iso_packet_loaded(iso_packet_loaded), .iso_in_token(iso_in_token));
    // ----------------------------------------
    // Pulse catcher and timeout
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (seen_clear)
            seen <= 8'h00;
        else
            seen <= seen | {iso_zero_length, iso_release, csr_clear, fifo_flush};
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        `CHK(avs_readdata, {24'h0, exp})
        avs_read <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic clear_seen();
        @(posedge ref_clk);
        seen_clear <= 1'b1;
        @(posedge ref_clk);
        seen_clear <= 1'b0;
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        rdc(UDA_POWER_CTRL_OFS, 8'h10);
        `CHK(port_enabled, 1'b0)
        rdc(UDA_FUNCTION_ADDRESS_OFS, 8'h00);
        rdc(UDA_IRQ_FLAGS_OFS, 8'h00);
        rdc(UDA_IRQ_ENABLE_OFS, 8'h05);
        rdc(4'h2, 8'h00);
    endtask
    task automatic t_init();
        wr(UDA_POWER_CTRL_OFS, 8'h08);
        wr(UDA_IRQ_ENABLE_OFS, 8'h07);
        wr(UDA_POWER_CTRL_OFS, 8'h00);
        wt(2);
        `CHK(port_enabled, 1'b1)
        wr(UDA_POWER_CTRL_OFS, 8'h10);
        rdc(UDA_POWER_CTRL_OFS, 8'h00);
        `CHK(port_enabled, 1'b1)
    endtask
    task automatic t_address();
        wr(UDA_FUNCTION_ADDRESS_OFS, 8'h2a);
        rdc(UDA_FUNCTION_ADDRESS_OFS, 8'haa);
        `CHK(match_address, 7'h00)
        uda_host_model_i.pulse(8'h01);
        rdc(UDA_FUNCTION_ADDRESS_OFS, 8'h2a);
        `CHK(match_address, 7'h2a)
    endtask
    task automatic t_bus_reset();
        clear_seen();
        fork
            uda_host_model_i.signal_line(0, 12);
            begin
                wt(7);
                rdc(UDA_POWER_CTRL_OFS, 8'h08);
            end
        join
        wt(6);
        `CHK(seen[1:0], 2'h3)
        `CHK(match_address, 7'h00)
        rdc(UDA_FUNCTION_ADDRESS_OFS, 8'h00);
        rdc(UDA_IRQ_ENABLE_OFS, 8'h05);
        rdc(UDA_IRQ_FLAGS_OFS, 8'h01);
        `CHK(irq, 1'b1)
        wr(UDA_IRQ_FLAGS_OFS, 8'h01);
        wt(1);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_suspend();
        wr(UDA_IRQ_ENABLE_OFS, 8'h07);
        wr(UDA_POWER_CTRL_OFS, 8'h01);
        uda_host_model_i.signal_line(1, 8);
        wt(6);
        `CHK(suspended, 1'b1)
        rdc(UDA_POWER_CTRL_OFS, 8'h03);
        rdc(UDA_IRQ_FLAGS_OFS, 8'h02);
        uda_host_model_i.signal_line(2, 8);
        wt(6);
        `CHK(suspended, 1'b0)
        rdc(UDA_IRQ_FLAGS_OFS, 8'h06);
        `CHK(irq, 1'b1)
        wr(UDA_IRQ_FLAGS_OFS, 8'h07);
        rdc(UDA_IRQ_FLAGS_OFS, 8'h00);
    endtask
    task automatic t_wakeup();
        uda_host_model_i.signal_line(1, 8);
        wt(6);
        `CHK(suspended, 1'b1)
        wr(UDA_POWER_CTRL_OFS, 8'h05);
        wt(3);
        `CHK(drive_resume, 1'b1)
        `CHK(suspended, 1'b0)
        wr(UDA_POWER_CTRL_OFS, 8'h01);
        wt(2);
        `CHK(drive_resume, 1'b0)
    endtask
    task automatic t_iso();
        wr(UDA_POWER_CTRL_OFS, 8'h80);
        clear_seen();
        uda_host_model_i.pulse(8'h04);
        uda_host_model_i.pulse(8'h20);
        wt(2);
        `CHK(seen[7:5], 3'h1)
        `CHK(seen[4:2], 3'h0)
        uda_host_model_i.pulse(8'h02);
        wt(2);
        `CHK(seen[4:2], 3'h1)
        wr(UDA_POWER_CTRL_OFS, 8'h08);
        wt(2);
        `CHK(port_enabled, 1'b0)
        rdc(UDA_POWER_CTRL_OFS, 8'h10);
        rdc(UDA_IRQ_ENABLE_OFS, 8'h05);
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_values();
        t_init();
        t_address();
        t_bus_reset();
        t_suspend();
        t_wakeup();
        t_iso();
        close_out();
    end
endmodule // testbench
